// ---- ictr_regs.sv ----
// Input channel tuning register bank: termination, impedance, input selection, equalizer bypass
// Operation
// R1 - Bits 3:2 of the back channel tuning register choose 50, 47.4, 45.3 or 37.7 ohm, 00 after reset.
// R2 - The forward channel impedance register is eight bits wide, resets to 0x00, 0x70 suits long cables.
// R3 - With override bit 7 clear the serial input follows the selection pin, with it set bit 6 decides.
// R4 - Under override, channel bit 0 picks input 0 and 1 picks input 1, the bit resetting to 0.
// R5 - Setting the bypass bit 6 stops adaptation and applies the manual level, clear after reset.
// R6 - Bits 7:4 of the report register read back the applied level as a thermometer code.
// R7 - Reserved fields hold their reset values regardless of writes, reserved addresses read as zero.
`timescale 1ns/10ps
`default_nettype none
module ictr_regs
  import ictr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_wr_data,
  output logic [7:0] reg_rd_data,
  output logic reg_rd_valid,
  input wire logic sel_pin,
  input wire logic [3:0] adaptive_level,
  input wire logic [3:0] manual_level,
  output logic [1:0] back_control_channel_term,
  output logic [7:0] serial_input_one_impedance,
  output logic active_channel,
  output logic equalizer_bypass_bit
);

  ictr_req_s req;
  ictr_state_s st_reg;
  ictr_state_s st_next;

  assign req = '{addr: reg_addr, wr_en: reg_wr_en, rd_en: reg_rd_en, wr_data: reg_wr_data};

  function automatic logic wr_hit(input ictr_req_s r, input logic [7:0] a);
    return r.wr_en && (r.addr == a);
  endfunction

  // Read value of one address; reserved fields show their reset values
  function automatic logic [7:0] read_word(input ictr_state_s s, input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      ICTR_ADDR_BACK_TUNE: begin
        v = ICTR_RST_BACK_TUNE;
        v[ICTR_TERM_MSB:ICTR_TERM_LSB] = s.term_code;
      end
      ICTR_ADDR_FWD_IMP: v = s.fwd_impedance;
      ICTR_ADDR_CHAN_SEL: begin
        v = ICTR_RST_CHAN_SEL;
        v[ICTR_OVR_BIT] = s.chan_override;
        v[ICTR_CHAN_BIT] = s.chan_choice;
      end
      ICTR_ADDR_EQ_CTRL: begin
        v = ICTR_RST_EQ_CTRL;
        v[ICTR_BYPASS_BIT] = s.eq_bypass;
      end
      ICTR_ADDR_EQ_REPORT: begin
        v = ICTR_RST_EQ_REPORT;
        v[ICTR_LEVEL_MSB:ICTR_LEVEL_LSB] = s.eq_level;
      end
      default: v = 8'h00; // [R7]
    endcase
    return v;
  endfunction

  always_comb begin
    st_next = st_reg;
    if (wr_hit(req, ICTR_ADDR_BACK_TUNE)) begin
      st_next.term_code = req.wr_data[ICTR_TERM_MSB:ICTR_TERM_LSB]; // [R1] [R7]
    end
    if (wr_hit(req, ICTR_ADDR_FWD_IMP)) begin
      st_next.fwd_impedance = req.wr_data; // [R2]
    end
    if (wr_hit(req, ICTR_ADDR_CHAN_SEL)) begin
      st_next.chan_override = req.wr_data[ICTR_OVR_BIT]; // [R3]
      st_next.chan_choice = req.wr_data[ICTR_CHAN_BIT]; // [R4]
    end
    if (wr_hit(req, ICTR_ADDR_EQ_CTRL)) begin
      st_next.eq_bypass = req.wr_data[ICTR_BYPASS_BIT]; // [R5]
    end
    st_next.active_channel = st_reg.chan_override ? st_reg.chan_choice : sel_pin; // [R3] [R4]
    st_next.eq_level = st_reg.eq_bypass ? manual_level : adaptive_level; // [R5] [R6]
    st_next.rd_valid = req.rd_en;
    st_next.rd_data = req.rd_en ? read_word(st_reg, req.addr) : 8'h00; // [R7]
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.term_code <= ICTR_TERM_50R0; // [R1]
      st_reg.fwd_impedance <= ICTR_RST_FWD_IMP; // [R2]
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rd_data = st_reg.rd_data;
  assign reg_rd_valid = st_reg.rd_valid;
  assign back_control_channel_term = st_reg.term_code;
  assign serial_input_one_impedance = st_reg.fwd_impedance;
  assign active_channel = st_reg.active_channel;
  assign equalizer_bypass_bit = st_reg.eq_bypass;

  sequence seq_write_back;
    reg_wr_en && reg_addr == ICTR_ADDR_BACK_TUNE;
  endsequence

  sequence seq_write_sel;
    reg_wr_en && reg_addr == ICTR_ADDR_CHAN_SEL;
  endsequence

  sequence seq_write_eq;
    reg_wr_en && reg_addr == ICTR_ADDR_EQ_CTRL;
  endsequence

  sequence seq_write_rsvd;
    reg_wr_en && reg_addr >= 8'h48 && reg_addr <= 8'h4b;
  endsequence

  sequence seq_write_report;
    reg_wr_en && reg_addr == ICTR_ADDR_EQ_REPORT;
  endsequence

  sequence seq_read_any;
    reg_rd_en && !reg_wr_en;
  endsequence

  AST_TERM_WRITE: assert property (@(posedge clk) disable iff (rst) // [R1]
    seq_write_back |=> back_control_channel_term == $past(reg_wr_data[3:2]))
    else $error("Termination code not taken from write");

  AST_IMP_WRITE: assert property (@(posedge clk) disable iff (rst) // [R2]
    reg_wr_en && reg_addr == ICTR_ADDR_FWD_IMP |=> serial_input_one_impedance == $past(reg_wr_data))
    else $error("Impedance value not taken from write");

  AST_PIN_FOLLOW: assert property (@(posedge clk) disable iff (rst) // [R3]
    !st_reg.chan_override && !reg_wr_en ##1 !st_reg.chan_override |-> active_channel == $past(sel_pin))
    else $error("Active input does not follow pin");

  AST_OVR_CHAN: assert property (@(posedge clk) disable iff (rst) // [R4]
    st_reg.chan_override ##1 st_reg.chan_override |-> active_channel == $past(st_reg.chan_choice))
    else $error("Override channel not applied");

  AST_BYPASS_LEVEL: assert property (@(posedge clk) disable iff (rst) // [R5]
    equalizer_bypass_bit |=> st_reg.eq_level == $past(manual_level))
    else $error("Manual level not applied in bypass");

  AST_REPORT_READ: assert property (@(posedge clk) disable iff (rst) // [R6]
    seq_read_any ##0 reg_addr == ICTR_ADDR_EQ_REPORT |=> reg_rd_data[7:4] == $past(st_reg.eq_level)
      && reg_rd_data[3:0] == 4'h0)
    else $error("Report register read wrong");

  AST_RSVD_CTRL: assert property (@(posedge clk) disable iff (rst) // [R7]
    seq_read_any ##0 reg_addr == ICTR_ADDR_EQ_CTRL |=> reg_rd_data[5:0] == 6'h20 && !reg_rd_data[7])
    else $error("Reserved control bits not at reset value");

  AST_RSVD_ADDR: assert property (@(posedge clk) disable iff (rst) // [R7]
    seq_read_any ##0 (reg_addr >= 8'h48 && reg_addr <= 8'h4b) |=> reg_rd_valid && reg_rd_data == 8'h00)
    else $error("Reserved address not zero");

  // Reset values, holding between writes and the remaining read fields
  AST_RESET_STATE: assert property (@(posedge clk) // [R1] [R2] [R4] [R5]
    rst |=> back_control_channel_term == ICTR_TERM_50R0 && serial_input_one_impedance == ICTR_RST_FWD_IMP
      && !st_reg.chan_override && !st_reg.chan_choice && !equalizer_bypass_bit && !reg_rd_valid)
    else $error("Settings not at reset value after reset");

  AST_TERM_HOLD: assert property (@(posedge clk) disable iff (rst) // [R1]
    !(reg_wr_en && reg_addr == ICTR_ADDR_BACK_TUNE) |=> $stable(back_control_channel_term))
    else $error("Termination code changed without a write");

  AST_IMP_HOLD: assert property (@(posedge clk) disable iff (rst) // [R2]
    !(reg_wr_en && reg_addr == ICTR_ADDR_FWD_IMP) |=> $stable(serial_input_one_impedance))
    else $error("Impedance value changed without a write");

  AST_SEL_WRITE: assert property (@(posedge clk) disable iff (rst) // [R3] [R4]
    seq_write_sel |=> st_reg.chan_override == $past(reg_wr_data[ICTR_OVR_BIT])
      && st_reg.chan_choice == $past(reg_wr_data[ICTR_CHAN_BIT]))
    else $error("Selection bits not taken from write");

  AST_BYPASS_WRITE: assert property (@(posedge clk) disable iff (rst) // [R5]
    seq_write_eq |=> equalizer_bypass_bit == $past(reg_wr_data[ICTR_BYPASS_BIT]))
    else $error("Bypass bit not taken from write");

  AST_ADAPT_LEVEL: assert property (@(posedge clk) disable iff (rst) // [R5] [R6]
    !equalizer_bypass_bit |=> st_reg.eq_level == $past(adaptive_level))
    else $error("Adaptive level not applied without bypass");

  AST_BACK_READ: assert property (@(posedge clk) disable iff (rst) // [R1]
    seq_read_any ##0 reg_addr == ICTR_ADDR_BACK_TUNE |=> reg_rd_data[3:2] == $past(back_control_channel_term))
    else $error("Termination code read wrong");

  AST_RSVD_BACK: assert property (@(posedge clk) disable iff (rst) // [R7]
    seq_read_any ##0 reg_addr == ICTR_ADDR_BACK_TUNE |=> reg_rd_data[7:4] == 4'h0 && reg_rd_data[1:0] == 2'h0)
    else $error("Reserved tuning bits not zero");

  AST_FWD_READ: assert property (@(posedge clk) disable iff (rst) // [R2]
    seq_read_any ##0 reg_addr == ICTR_ADDR_FWD_IMP |=> reg_rd_data == $past(serial_input_one_impedance))
    else $error("Impedance value read wrong");

  AST_SEL_READ: assert property (@(posedge clk) disable iff (rst) // [R3] [R4]
    seq_read_any ##0 reg_addr == ICTR_ADDR_CHAN_SEL
      |=> reg_rd_data[7:6] == $past({st_reg.chan_override, st_reg.chan_choice}))
    else $error("Selection bits read wrong");

  AST_RSVD_SEL: assert property (@(posedge clk) disable iff (rst) // [R7]
    seq_read_any ##0 reg_addr == ICTR_ADDR_CHAN_SEL |=> reg_rd_data[5:0] == 6'h00)
    else $error("Reserved selection bits not zero");

  AST_CTRL_READ: assert property (@(posedge clk) disable iff (rst) // [R5]
    seq_read_any ##0 reg_addr == ICTR_ADDR_EQ_CTRL |=> reg_rd_data[6] == $past(equalizer_bypass_bit))
    else $error("Bypass bit read wrong");

  AST_RSVD_WRITE: assert property (@(posedge clk) disable iff (rst) // [R7]
    seq_write_rsvd |=> $stable(back_control_channel_term) && $stable(serial_input_one_impedance)
      && $stable(equalizer_bypass_bit) && $stable(st_reg.chan_override) && $stable(st_reg.chan_choice))
    else $error("Write to reserved address changed a setting");

  AST_REPORT_RO: assert property (@(posedge clk) disable iff (rst) // [R6] [R7]
    seq_write_report |=> $stable(back_control_channel_term) && $stable(serial_input_one_impedance)
      && $stable(equalizer_bypass_bit) && $stable(st_reg.chan_override) && $stable(st_reg.chan_choice))
    else $error("Write to report register changed a setting");

endmodule
`default_nettype wire

// ---- ictr_pkg.sv ----
// Package for the input channel tuning register bank: offsets, fields, reset values, state
package ictr_pkg;

  localparam logic [7:0] ICTR_ADDR_BACK_TUNE = 8'h46;
  localparam logic [7:0] ICTR_ADDR_FWD_IMP = 8'h47;
  localparam logic [7:0] ICTR_ADDR_CHAN_SEL = 8'h4c;
  localparam logic [7:0] ICTR_ADDR_EQ_CTRL = 8'h4d;
  localparam logic [7:0] ICTR_ADDR_EQ_REPORT = 8'h4e;

  localparam logic [7:0] ICTR_RST_BACK_TUNE = 8'h00;
  localparam logic [7:0] ICTR_RST_FWD_IMP = 8'h00;
  localparam logic [7:0] ICTR_RST_CHAN_SEL = 8'h00;
  localparam logic [7:0] ICTR_RST_EQ_CTRL = 8'h20;
  localparam logic [7:0] ICTR_RST_EQ_REPORT = 8'h00;

  // Field positions
  localparam int ICTR_TERM_LSB = 2;
  localparam int ICTR_TERM_MSB = 3;
  localparam int ICTR_OVR_BIT = 7;
  localparam int ICTR_CHAN_BIT = 6;
  localparam int ICTR_BYPASS_BIT = 6;
  localparam int ICTR_LEVEL_LSB = 4;
  localparam int ICTR_LEVEL_MSB = 7;

  // Termination codes
  localparam logic [1:0] ICTR_TERM_50R0 = 2'h0;
  localparam logic [1:0] ICTR_TERM_47R4 = 2'h1;
  localparam logic [1:0] ICTR_TERM_45R3 = 2'h2;
  localparam logic [1:0] ICTR_TERM_37R7 = 2'h3;

  // Suggested impedance value for long cables with mismatch
  localparam logic [7:0] ICTR_IMP_LONG_CABLE = 8'h70;

  typedef struct packed {
    logic [7:0] addr;
    logic wr_en;
    logic rd_en;
    logic [7:0] wr_data;
  } ictr_req_s;

  typedef struct packed {
    logic [1:0] term_code;
    logic [7:0] fwd_impedance;
    logic chan_override;
    logic chan_choice;
    logic eq_bypass;
    logic active_channel;
    logic [3:0] eq_level;
    logic [7:0] rd_data;
    logic rd_valid;
  } ictr_state_s;

endpackage

// ---- tb_ictr_regs.sv ----
// Self-checking testbench for the input channel tuning register bank
`timescale 1ns/10ps
`default_nettype none
module tb_ictr_regs;
  import ictr_pkg::*;
  logic clk = 0, rst = 1, wr_en = 0, rd_en = 0, sel_pin = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, v, imp;
  logic rd_valid, chan, bypass, byp_exp;
  logic [3:0] alvl = 4'h0, mlvl = 4'h0;
  logic [1:0] term;
  logic [3:0] thermo [5] = '{4'h0, 4'h1, 4'h3, 4'h7, 4'hf};
  int error_cnt = 0, checks_done = 0, seed = 5, i;
  always #20 clk = ~clk;
  ictr_regs dut_u (.clk(clk), .rst(rst), .reg_addr(addr), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
    .reg_wr_data(wdata), .reg_rd_data(rdata), .reg_rd_valid(rd_valid), .sel_pin(sel_pin),
    .adaptive_level(alvl), .manual_level(mlvl), .back_control_channel_term(term),
    .serial_input_one_impedance(imp), .active_channel(chan), .equalizer_bypass_bit(bypass));
  function automatic logic [7:0] lvl_exp(input logic b);
    return {b ? mlvl : alvl, 4'h0};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step;
    @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    step();
    addr = a;
    wdata = d;
    wr_en = 1;
    step();
    wr_en = 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    step();
    addr = a;
    rd_en = 1;
    step();
    rd_en = 0;
    chk({7'h00, rd_valid}, 8'h01);
    chk(rdata, exp);
  endtask
  task automatic tally_and_finish;
    $display("Checks %0d, errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    #50000;
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    repeat (6) @(posedge clk);
    #1 rst = 0;
    rd(ICTR_ADDR_BACK_TUNE, 8'h00);
    rd(ICTR_ADDR_FWD_IMP, 8'h00);
    rd(ICTR_ADDR_CHAN_SEL, 8'h00);
    rd(ICTR_ADDR_EQ_CTRL, 8'h20);
    rd(ICTR_ADDR_EQ_REPORT, 8'h00);
    wr(8'h49, 8'hff);
    rd(8'h49, 8'h00);
    wr(ICTR_ADDR_EQ_REPORT, 8'hff);
    rd(ICTR_ADDR_EQ_REPORT, 8'h00);
    for (i = 0; i < 4; i++) begin
      v = 8'($random(seed));
      wr(ICTR_ADDR_BACK_TUNE, {v[7:4], i[1:0], v[1:0]});
      chk({6'h00, term}, {6'h00, i[1:0]});
      rd(ICTR_ADDR_BACK_TUNE, {4'h0, i[1:0], 2'h0});
    end
    for (i = 0; i < 3; i++) begin
      v = (i == 0) ? ICTR_IMP_LONG_CABLE : 8'($random(seed));
      wr(ICTR_ADDR_FWD_IMP, v);
      chk(imp, v);
      rd(ICTR_ADDR_FWD_IMP, v);
    end
    for (i = 0; i < 4; i++) begin
      v = 8'($random(seed));
      sel_pin = v[0] ^ i[0];
      step();
      step();
      chk({7'h00, chan}, {7'h00, sel_pin});
    end
    sel_pin = 0;
    wr(ICTR_ADDR_CHAN_SEL, {2'b11, v[5:0]});
    step();
    chk({7'h00, chan}, 8'h01);
    rd(ICTR_ADDR_CHAN_SEL, 8'hc0);
    sel_pin = 1;
    wr(ICTR_ADDR_CHAN_SEL, 8'h80);
    step();
    chk({7'h00, chan}, 8'h00);
    wr(ICTR_ADDR_CHAN_SEL, 8'h00);
    step();
    chk({7'h00, chan}, 8'h01);
    for (i = 0; i < 6; i++) begin
      v = 8'($random(seed));
      byp_exp = i[0];
      wr(ICTR_ADDR_EQ_CTRL, {v[7], byp_exp, v[5:0]});
      chk({7'h00, bypass}, {7'h00, byp_exp});
      rd(ICTR_ADDR_EQ_CTRL, {1'b0, byp_exp, 6'h20});
      v = 8'($random(seed));
      alvl = thermo[v[3:0] % 5];
      mlvl = thermo[(v[3:0] % 5 + 1 + v[7:4] % 4) % 5];
      rd(ICTR_ADDR_EQ_REPORT, lvl_exp(byp_exp));
    end
    rst = 1;
    step();
    rst = 0;
    rd(ICTR_ADDR_FWD_IMP, 8'h00);
    rd(ICTR_ADDR_BACK_TUNE, 8'h00);
    rd(ICTR_ADDR_CHAN_SEL, 8'h00);
    rd(ICTR_ADDR_EQ_CTRL, 8'h20);
    tally_and_finish();
  end
endmodule
`default_nettype wire
